// ==== core/pwm_bank.sv ====
`timescale 1ns/100ps
// What this block does
// - Four independent PWM channels zero to three, each with own waveform.
// - Per channel 10-bit start value, writable and readable.
// - Per channel 10-bit toggle point, writable and readable.
// - Per channel 10-bit running count, read only, writes ignored.
// - One 12-bit setup register shared by all four channels.
// - Setup register turns each channel on or off individually.
// - Setup register picks system clock or tick per channel; clk_sel picks slow or external tick.
// - Setup register inverts each channel's output independently.
// - Outputs route only to pins 26, 27, 13 and one of pair 14/28.
module pwm_bank
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // External tick sources, one per channel
  input wire logic [3:0] ext_tick_pin,
  // Routed pins and their enables
  output logic port_pin_26,
  output logic port_pin_26_oe,
  output logic port_pin_27,
  output logic port_pin_27_oe,
  output logic port_pin_13,
  output logic port_pin_13_oe,
  output logic dual_bonded_pin_14_28,
  output logic dual_bonded_pin_14_28_oe,
  output logic dual_bonded_pick_28
);
  localparam int N = pwm_bank_pkg::CHANNELS;
  localparam int SLOW_GAP = pwm_bank_pkg::SLOW_DIV;

  logic [11:0] setup_r;
  logic [8:0] route_r;
  logic [3:0] clk_sel_r;
  logic [9:0] start_r [N];
  logic [9:0] toggle_r [N];
  logic [9:0] count_w [N];
  logic [3:0] wave_w;
  logic [9:0] slow_cnt_r;
  logic slow_tick_r;
  logic [3:0] ext_s1_r;
  logic [3:0] ext_s2_r;
  logic [3:0] ext_s3_r;
  logic [3:0] tick_w;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [7:0] rd_addr;
  logic [31:0] rdata_nxt;

  // Channel index of an address inside the per-channel window
  function automatic logic [1:0] chan_of(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - pwm_bank_pkg::OFS_CHAN_BASE;
    chan_of = rel[5:4];
  endfunction

  function automatic logic in_chan(input logic [7:0] a);
    in_chan = (a >= pwm_bank_pkg::OFS_CHAN_BASE) && (a < 8'h50);
  endfunction

  function automatic logic [1:0] route_field(input logic [8:0] r, input int pos);
    route_field = r[pos +: 2];
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Write address captured in the address phase, data taken in the data phase
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      setup_r <= pwm_bank_pkg::SETUP_RESET;
      route_r <= pwm_bank_pkg::ROUTE_RESET;
      clk_sel_r <= pwm_bank_pkg::CLKSEL_RESET;
    end
    else if (wr_pend_r)
    begin
      if (wr_addr_r == pwm_bank_pkg::OFS_SETUP)
        setup_r <= hwdata[11:0];
      else if (wr_addr_r == pwm_bank_pkg::OFS_PIN_ROUTE)
        route_r <= hwdata[8:0];
      else if (wr_addr_r == pwm_bank_pkg::OFS_CLK_SEL)
        clk_sel_r <= hwdata[3:0];
    end
  end

  generate
    for (genvar c = 0; c < N; c++)
    begin : g_regs
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          start_r[c] <= pwm_bank_pkg::START_RESET;
          toggle_r[c] <= pwm_bank_pkg::TOGGLE_RESET;
        end
        else if (wr_pend_r && in_chan(wr_addr_r) && chan_of(wr_addr_r) == 2'(c))
        begin
          if (wr_addr_r[3:0] == pwm_bank_pkg::OFS_START)
            start_r[c] <= hwdata[9:0];
          else if (wr_addr_r[3:0] == pwm_bank_pkg::OFS_TOGGLE)
            toggle_r[c] <= hwdata[9:0];
        end
      end
    end
  endgenerate

  // Read data decoded from the address phase, registered into the data phase
  assign rd_addr = haddr[7:0];

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (rd_addr == pwm_bank_pkg::OFS_SETUP)
      rdata_nxt = {20'h00000, setup_r};
    else if (rd_addr == pwm_bank_pkg::OFS_PIN_ROUTE)
      rdata_nxt = {23'h000000, route_r};
    else if (rd_addr == pwm_bank_pkg::OFS_CLK_SEL)
      rdata_nxt = {28'h0000000, clk_sel_r};
    else if (in_chan(rd_addr) && rd_addr[3:0] == pwm_bank_pkg::OFS_START)
      rdata_nxt = {22'h000000, start_r[chan_of(rd_addr)]};
    else if (in_chan(rd_addr) && rd_addr[3:0] == pwm_bank_pkg::OFS_TOGGLE)
      rdata_nxt = {22'h000000, toggle_r[chan_of(rd_addr)]};
    else if (in_chan(rd_addr) && rd_addr[3:0] == pwm_bank_pkg::OFS_COUNT)
      rdata_nxt = {22'h000000, count_w[chan_of(rd_addr)]};
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
      hrdata <= rdata_nxt;
  end

  // Internal slow tick shared by channels that select it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      slow_cnt_r <= 10'h000;
      slow_tick_r <= 1'b0;
    end
    else if (slow_cnt_r == pwm_bank_pkg::SLOW_DIV_M1)
    begin
      slow_cnt_r <= 10'h000;
      slow_tick_r <= 1'b1;
    end
    else
    begin
      slow_cnt_r <= slow_cnt_r + 10'h001;
      slow_tick_r <= 1'b0;
    end
  end

  // External ticks: two stages, then a third for rising-edge detect
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ext_s1_r <= 4'h0;
      ext_s2_r <= 4'h0;
      ext_s3_r <= 4'h0;
    end
    else
    begin
      ext_s1_r <= ext_tick_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  generate
    for (genvar c = 0; c < N; c++)
    begin : g_chan
      // Source: setup bit picks system clock or tick; clk_sel picks slow or external tick
      assign tick_w[c] = setup_r[pwm_bank_pkg::SETUP_CLK_POS + c] ? 1'b1 :
                         (clk_sel_r[c] ? (ext_s2_r[c] & ~ext_s3_r[c]) : slow_tick_r);
      pwm_channel u_chan
      (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .enable(setup_r[pwm_bank_pkg::SETUP_EN_POS + c]),
        .tick(tick_w[c]),
        .phase_inv(setup_r[pwm_bank_pkg::SETUP_PHASE_POS + c]),
        .start_value(start_r[c]),
        .toggle_point(toggle_r[c]),
        .running_count(count_w[c]),
        .wave(wave_w[c])
      );
    end
  endgenerate

  // Only four pins are reachable; pair 14/28 drives just one member
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      port_pin_26 <= 1'b0;
      port_pin_27 <= 1'b0;
      port_pin_13 <= 1'b0;
      dual_bonded_pin_14_28 <= 1'b0;
      port_pin_26_oe <= 1'b0;
      port_pin_27_oe <= 1'b0;
      port_pin_13_oe <= 1'b0;
      dual_bonded_pin_14_28_oe <= 1'b0;
      dual_bonded_pick_28 <= 1'b0;
    end
    else
    begin
      port_pin_26 <= wave_w[route_field(route_r, pwm_bank_pkg::ROUTE_PIN26_POS)];
      port_pin_27 <= wave_w[route_field(route_r, pwm_bank_pkg::ROUTE_PIN27_POS)];
      port_pin_13 <= wave_w[route_field(route_r, pwm_bank_pkg::ROUTE_PIN13_POS)];
      dual_bonded_pin_14_28 <= wave_w[route_field(route_r, pwm_bank_pkg::ROUTE_PIN1428_POS)];
      port_pin_26_oe <= setup_r[route_field(route_r, pwm_bank_pkg::ROUTE_PIN26_POS)];
      port_pin_27_oe <= setup_r[route_field(route_r, pwm_bank_pkg::ROUTE_PIN27_POS)];
      port_pin_13_oe <= setup_r[route_field(route_r, pwm_bank_pkg::ROUTE_PIN13_POS)];
      dual_bonded_pin_14_28_oe <= setup_r[route_field(route_r, pwm_bank_pkg::ROUTE_PIN1428_POS)];
      dual_bonded_pick_28 <= route_r[pwm_bank_pkg::ROUTE_PAIR_SEL_POS];
    end
  end

  a_setup_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_pend_r && wr_addr_r == pwm_bank_pkg::OFS_SETUP |=> setup_r == $past(hwdata[11:0]))
    else $error("setup register did not take written value");

  a_count_ro: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_pend_r && in_chan(wr_addr_r) && wr_addr_r[3:0] == pwm_bank_pkg::OFS_COUNT
    |=> start_r[0] == $past(start_r[0]) && toggle_r[0] == $past(toggle_r[0]))
    else $error("write to running count disturbed channel registers");

  a_start_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_pend_r && wr_addr_r == pwm_bank_pkg::OFS_CHAN_BASE |=> start_r[0] == $past(hwdata[9:0]))
    else $error("start value not stored");

  a_toggle_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_pend_r && wr_addr_r == 8'h14 |=> toggle_r[0] == $past(hwdata[9:0]))
    else $error("toggle point not stored");

  sequence s_enable_rise;
    !setup_r[0] ##1 setup_r[0];
  endsequence

  a_enable_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_enable_rise |=> count_w[0] == $past(start_r[0]))
    else $error("counter did not load start value on enable");

  a_off_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !setup_r[1] ##1 !setup_r[1] |=> !wave_w[1])
    else $error("disabled channel drives a waveform");

  a_wrap_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
    setup_r[2] && $past(setup_r[2]) && tick_w[2] && count_w[2] == pwm_bank_pkg::CNT_ALL_ONES
    && $stable(setup_r) |=> count_w[2] == $past(start_r[2]))
    else $error("counter did not reload after all ones");

  a_pin_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 port_pin_26 == $past(wave_w[route_r[1:0]]) || $changed(route_r))
    else $error("pin 26 does not follow its routed channel");

  a_fast_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    setup_r[7] && setup_r[3] && $past(setup_r[3]) && $stable(setup_r) && $stable(start_r[3])
    && count_w[3] != pwm_bank_pkg::CNT_ALL_ONES |=> count_w[3] == $past(count_w[3]) + 10'h001)
    else $error("system-clock channel did not advance each cycle");

  a_read_setup: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hready && hsel && htrans[1] && !hwrite && haddr[7:0] == pwm_bank_pkg::OFS_SETUP
    |=> hrdata == {20'h00000, $past(setup_r)})
    else $error("setup register read back wrong");

  a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(hready && hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  a_count_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !setup_r[2] |=> $stable(count_w[2]))
    else $error("disabled channel count moved");

  a_oe_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 port_pin_13_oe == $past(setup_r[route_r[5:4]]))
    else $error("pin 13 enable does not follow its channel");

  a_pick_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 dual_bonded_pick_28 == $past(route_r[pwm_bank_pkg::ROUTE_PAIR_SEL_POS]))
    else $error("pair member select does not follow routing");

  // One-value range keeps the tick spacing exact without a long plain delay
  a_slow_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
    slow_tick_r |-> ##[SLOW_GAP:SLOW_GAP] slow_tick_r)
    else $error("internal tick spacing wrong");

  a_ext_advance: assert property (@(posedge ref_clk) disable iff (!rst_n)
    setup_r[2] && $past(setup_r[2]) && !setup_r[6] && clk_sel_r[2] && ext_s2_r[2] && !ext_s3_r[2]
    && count_w[2] != pwm_bank_pkg::CNT_ALL_ONES |=> count_w[2] == $past(count_w[2]) + 10'h001)
    else $error("external tick edge did not advance the count");

  a_no_tick_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    setup_r[2] && $past(setup_r[2]) && !tick_w[2] |=> $stable(count_w[2]))
    else $error("count moved without a tick");

  // Pin level lags the count by one register stage
  sequence s_hit_toggle;
    setup_r[0] && $past(setup_r[0]) && tick_w[0] && count_w[0] != pwm_bank_pkg::CNT_ALL_ONES
    && count_w[0] + 10'h001 == toggle_r[0] ##1 setup_r[0];
  endsequence

  a_toggle_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_hit_toggle |=> wave_w[0] == !$past(setup_r[8]))
    else $error("output did not change level at toggle point");

  sequence s_wrap_point;
    setup_r[0] && $past(setup_r[0]) && tick_w[0] && count_w[0] == pwm_bank_pkg::CNT_ALL_ONES ##1 setup_r[0];
  endsequence

  a_wrap_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_wrap_point |=> wave_w[0] == $past(setup_r[8]))
    else $error("output did not return to its phase level after reload");
endmodule

// ==== core/pwm_bank_pkg.sv ====
package pwm_bank_pkg;
  localparam int CHANNELS = 4;
  localparam int CNT_W = 10;
  localparam int SETUP_W = 12;
  // Register word offsets (byte addresses)
  localparam logic [7:0] OFS_SETUP = 8'h00;
  localparam logic [7:0] OFS_PIN_ROUTE = 8'h04;
  localparam logic [7:0] OFS_CLK_SEL = 8'h08;
  localparam logic [7:0] OFS_CHAN_BASE = 8'h10;
  localparam logic [7:0] OFS_CHAN_STRIDE = 8'h10;
  localparam logic [3:0] OFS_START = 4'h0;
  localparam logic [3:0] OFS_TOGGLE = 4'h4;
  localparam logic [3:0] OFS_COUNT = 4'h8;
  // Shared setup fields: [3:0] enable per channel, [7:4] clock select, [11:8] phase invert
  localparam int SETUP_EN_POS = 0;
  localparam int SETUP_CLK_POS = 4;
  localparam int SETUP_PHASE_POS = 8;
  localparam logic [11:0] SETUP_RESET = 12'h000;
  localparam logic [9:0] START_RESET = 10'h000;
  localparam logic [9:0] TOGGLE_RESET = 10'h200;
  localparam logic [9:0] CNT_ALL_ONES = 10'h3ff;
  // Slow tick divider: 100 MHz down to about 128 kHz
  localparam int CLK_HZ = 100_000_000;
  localparam int SLOW_HZ = 128_000;
  localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam logic [9:0] SLOW_DIV_M1 = 10'(SLOW_DIV - 1);
  // Pin routing: 2 bits per pin, selects channel driving it
  localparam int ROUTE_W = 9;
  localparam int ROUTE_PIN26_POS = 0;
  localparam int ROUTE_PIN27_POS = 2;
  localparam int ROUTE_PIN13_POS = 4;
  localparam int ROUTE_PIN1428_POS = 6;
  localparam int ROUTE_PAIR_SEL_POS = 8;
  localparam logic [8:0] ROUTE_RESET = 9'h0e4;
  // Per-channel external tick selects
  localparam logic [3:0] CLKSEL_RESET = 4'h0;
endpackage

// ==== core/pwm_channel.sv ====
`timescale 1ns/100ps
module pwm_channel
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic tick,
  input wire logic phase_inv,
  input wire logic [9:0] start_value,
  input wire logic [9:0] toggle_point,
  // Results
  output logic [9:0] running_count,
  output logic wave
);
  logic run_r;
  logic level_r;

  // Enable edge loads start; tick advances; all ones reloads
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      running_count <= pwm_bank_pkg::START_RESET;
      run_r <= 1'b0;
    end
    else
    begin
      run_r <= enable;
      if (enable && !run_r)
        running_count <= start_value;
      else if (enable && tick)
      begin
        if (running_count == pwm_bank_pkg::CNT_ALL_ONES)
          running_count <= start_value;
        else
          running_count <= running_count + 10'h001;
      end
    end
  end

  // Low from reload, high from toggle point
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      level_r <= 1'b0;
    else if (!enable)
      level_r <= 1'b0;
    else if (enable && !run_r)
      level_r <= 1'b0;
    else if (tick && running_count == pwm_bank_pkg::CNT_ALL_ONES)
      level_r <= 1'b0;
    else if (tick && running_count + 10'h001 == toggle_point)
      level_r <= 1'b1;
  end

  // Phase setting inverts the waveform; output low while disabled
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      wave <= 1'b0;
    else
      wave <= enable & (level_r ^ phase_inv);
  end
endmodule

// ==== testbench/pwm_load.sv ====
`timescale 1ns/100ps
module pwm_load
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pin under load
  input wire logic pin,
  input wire logic pin_oe,
  // Last complete level widths in cycles
  output int high_len,
  output int low_len
);
  int run;
  logic last;
  // An undriven pin floats, so nothing is measured then
  always @(posedge ref_clk)
  begin
    if (!rst_n || !pin_oe)
    begin
      run <= 0;
      last <= 1'b0;
      high_len <= 0;
      low_len <= 0;
    end
    else if (pin !== last)
    begin
      if (last)
        high_len <= run;
      else
        low_len <= run;
      run <= 1;
      last <= pin;
    end
    else
      run <= run + 1;
  end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] ext_tick_pin = 4'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] pins;
  logic [3:0] oes;
  logic pick_28;
  int hi[4];
  int lo[4];
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  logic [9:0] st[4];
  logic [9:0] tg[4];
  logic [3:0] ph;
  logic [31:0] q;
  logic [31:0] frozen;
  int n;

  always #5 ref_clk = ~ref_clk;

  pwm_bank u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_tick_pin(ext_tick_pin),
    .port_pin_26(pins[0]), .port_pin_26_oe(oes[0]), .port_pin_27(pins[1]), .port_pin_27_oe(oes[1]),
    .port_pin_13(pins[2]), .port_pin_13_oe(oes[2]), .dual_bonded_pin_14_28(pins[3]),
    .dual_bonded_pin_14_28_oe(oes[3]), .dual_bonded_pick_28(pick_28));

  for (genvar i = 0; i < 4; i++)
  begin : g_load
    pwm_load u_load (.ref_clk(ref_clk), .rst_n(rst_n), .pin(pins[i]), .pin_oe(oes[i]),
      .high_len(hi[i]), .low_len(lo[i]));
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_w(input string what, input int exp, input int got);
    compares++;
    if (got != exp)
    begin
      err_total++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Address phase held until hready, then data phase until hready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1)
      @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1)
      @(posedge ref_clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk($sformatf("reg %h", a), exp, r);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  function automatic logic [7:0] ch(input int c, input logic [3:0] o);
    return 8'h10 + 8'(c * 16) + {4'h0, o};
  endfunction

  // Output inversion swaps the two level widths
  function automatic int exp_w(input logic [9:0] s, input logic [9:0] t, input logic inv, input logic high);
    return (high ^ inv) ? 1024 - int'(t) : int'(t) - int'(s);
  endfunction

  initial
  begin
    void'($urandom(87620));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("oe at reset", 32'h0, {28'h0, oes});
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h0e4);
    rchk(8'h08, 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      rchk(ch(c, 4'h0), 32'h0);
      rchk(ch(c, 4'h4), 32'h200);
    end
    $display("test reset values done");
    for (int c = 0; c < 4; c++)
    begin
      q = $urandom;
      wr(ch(c, 4'h0), q);
      rchk(ch(c, 4'h0), q & 32'h3ff);
      q = $urandom;
      wr(ch(c, 4'h4), q);
      rchk(ch(c, 4'h4), q & 32'h3ff);
    end
    q = $urandom;
    wr(8'h00, q & 32'hfffffff0);
    rchk(8'h00, q & 32'hff0);
    wr(8'hfc, 32'hffffffff);
    rchk(8'hfc, 32'h0);
    $display("test register access done");
    // Short periods keep width checks quick; all ones ends each period
    ph = 4'($urandom);
    // Pin 26 rerouted to channel 3 must show a width unlike channel 0
    ph[3] = ph[0];
    for (int c = 0; c < 4; c++)
    begin
      st[c] = 10'h3c0;
      tg[c] = 10'h3c1 + 10'(c * 15) + 10'($urandom_range(0, 14));
      wr(ch(c, 4'h0), {22'h0, st[c]});
      wr(ch(c, 4'h4), {22'h0, tg[c]});
    end
    wr(8'h00, {20'h0, ph, 8'hff});
    repeat (300) @(posedge ref_clk);
    chk("oe all on", 32'hf, {28'h0, oes});
    for (int c = 0; c < 4; c++)
    begin
      chk_w($sformatf("high width %0d", c), exp_w(st[c], tg[c], ph[c], 1'b1), hi[c]);
      chk_w($sformatf("low width %0d", c), exp_w(st[c], tg[c], ph[c], 1'b0), lo[c]);
    end
    $display("test waveforms done");
    wr(8'h00, {20'h0, ph, 8'hfb});
    repeat (4) @(posedge ref_clk);
    chk("oe ch2 off", 32'hb, {28'h0, oes});
    chk("pin ch2 off", 32'h0, {31'h0, pins[2]});
    xfer(1'b0, ch(2, 4'h8), 32'h0, frozen);
    wr(ch(2, 4'h8), ~frozen);
    rchk(ch(2, 4'h8), frozen);
    wr(8'h04, 32'h1e7);
    repeat (300) @(posedge ref_clk);
    chk("pick 28", 32'h1, {31'h0, pick_28});
    chk("oe routed", 32'hb, {28'h0, oes});
    chk_w("pin26 from ch3", exp_w(st[3], tg[3], ph[3], 1'b1), hi[0]);
    $display("test routing done");
    wr(ch(2, 4'h0), 32'h0);
    wr(8'h08, 32'h4);
    wr(8'h00, 32'h4);
    repeat (4) @(posedge ref_clk);
    n = $urandom_range(3, 12);
    repeat (n)
    begin
      ext_tick_pin[2] <= 1'b1;
      repeat (3) @(posedge ref_clk);
      ext_tick_pin[2] <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    rchk(ch(2, 4'h8), 32'(n));
    $display("test external tick done");
    report_and_stop();
  end
endmodule
